// File: verilog/irq_mode_pkg.sv
// Purpose: Shared constants for the interrupt and operating mode control block.
// Assumes: The reference clock is the system clock, one reference cycle per edge.
// Notes:   Half-cycle access figures are kept doubled and converted here.
package irq_mode_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 8;
    localparam int          CNT_W  = 12;

    // Register offsets on the demultiplexed host bus.
    localparam logic [7:0]  INTERRUPT_STATUS_ADDR = 8'h0E;
    localparam logic [7:0]  INTERRUPT_MASK_ADDR   = 8'h0E;
    localparam logic [7:0]  OPERATING_MODE_ADDR   = 8'h0F;

    localparam logic [7:0]  INTERRUPT_STATUS_RESET = 8'h00;
    localparam logic [7:0]  INTERRUPT_MASK_RESET   = 8'h00;
    localparam logic [7:0]  OPERATING_MODE_RESET   = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ_VALUE    = 8'h00;

    // Status and mask bit positions.
    localparam int TIMER_EVENT_FLAG_BIT          = 7;
    localparam int SIGNALING_QUEUE_FLAG_BIT      = 6;
    localparam int MONITOR_COMMAND_DONE_FLAG_BIT = 5;
    localparam int MONITOR_CHANNEL_FOUND_FLAG_BIT = 4;
    localparam int FRAMING_CHANGE_FLAG_BIT       = 3;
    localparam int INPUT_MISMATCH_FLAG_BIT       = 2;
    localparam int SYNC_WINDOW_OPEN_FLAG_BIT     = 1;
    localparam int SYNC_OVERRUN_FLAG_BIT         = 0;

    // Operating mode register fields.
    localparam int OPERATING_MODE_FIELD_HI       = 7;
    localparam int OPERATING_MODE_FIELD_LO       = 6;
    localparam int MONITOR_HANDSHAKE_SELECT_BIT  = 2;

    localparam logic [1:0]  MODE_CM_RESET = 2'h0;
    localparam logic [1:0]  MODE_TEST     = 2'h1;
    localparam logic [1:0]  MODE_CM_INIT  = 2'h2;
    localparam logic [1:0]  MODE_NORMAL   = 2'h3;

    // Access durations in reference clock cycles; the *_HALF_CYCLES figures are in half cycles.
    localparam int CM_RESET_CYCLES          = 256;
    localparam int CM_INIT_HALF_CYCLES      = 5;
    localparam int NORMAL_ACCESS_HALF_CYCLES = 19;
    localparam int TRISTATE_INIT_CYCLES     = 1035;
    localparam int TEST_ACCESS_CYCLES       = 2057;
    // A longest time rounds down, a plain duration rounds up.
    localparam int CM_INIT_CYCLES       = CM_INIT_HALF_CYCLES / 2;
    localparam int NORMAL_ACCESS_CYCLES = (NORMAL_ACCESS_HALF_CYCLES + 1) / 2;

    localparam int INT_BLANK_CYCLES = 1;

endpackage

// File: verilog/event_flag_cell.sv
// Purpose: One sticky interrupt flag with internal hold while masked.
// Assumes: Set and clear are single-cycle pulses on the system clock.
// Notes:   A set in the clearing cycle wins; a masked flag survives status reads.
`timescale 1ns/100ps
module event_flag_cell (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_set,
    input  wire logic i_clear,
    input  wire logic i_mask,
    output logic      o_visible
);
    import irq_mode_pkg::*;

    logic flag_reg;
    logic flag_next;

    // Only a flag the host could see is cleared by its read.
    assign flag_next = i_set | (flag_reg & ~(i_clear & ~i_mask));
    assign o_visible = flag_reg & ~i_mask;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    a_set_wins_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_set |=> flag_reg)
        else $error("flag lost a set event");

    a_masked_flag_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (flag_reg && i_mask) |=> flag_reg)
        else $error("masked flag was not held");

endmodule

// File: verilog/mem_access_timer.sv
// Purpose: Times one control memory access according to the operating mode.
// Assumes: A start pulse given while an access is still running is ignored, not queued.
// Notes:   Busy stands exactly for the mode's access length.
`timescale 1ns/100ps
module mem_access_timer (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rstn,
    input  wire logic                      i_start,
    input  wire logic                      i_full_tristate,
    input  wire logic [1:0]                i_mode,
    output logic                           o_busy,
    output logic                           o_done
);
    import irq_mode_pkg::*;

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] load_value;

    function automatic logic [CNT_W-1:0] access_cycles(input logic [1:0] mode,
                                                       input logic       full);
        case (mode)
            MODE_CM_RESET: access_cycles = CNT_W'(CM_RESET_CYCLES);
            MODE_CM_INIT:  access_cycles = CNT_W'(CM_INIT_CYCLES);
            MODE_NORMAL:   access_cycles = full ? CNT_W'(TRISTATE_INIT_CYCLES)
                                                : CNT_W'(NORMAL_ACCESS_CYCLES);
            MODE_TEST:     access_cycles = CNT_W'(TEST_ACCESS_CYCLES);
            default:       access_cycles = CNT_W'(NORMAL_ACCESS_CYCLES);
        endcase
    endfunction

    assign load_value = access_cycles(i_mode, i_full_tristate);
    assign count_next = (i_start && count_reg == '0) ? load_value
                      : (count_reg != '0) ? count_reg - CNT_W'(1) : count_reg;
    assign o_busy     = (count_reg != '0);
    assign o_done     = (count_reg == CNT_W'(1));

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    sequence s_init_start;
        i_start && !o_busy && i_mode == MODE_CM_INIT;
    endsequence

    a_init_access_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_init_start |=> o_busy [*2] ##1 !o_busy)
        else $error("init mode access length wrong");

    a_normal_access_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_start && !o_busy && i_mode == MODE_NORMAL && !i_full_tristate)
        |=> o_busy [*8] ##1 o_busy [*2] ##1 !o_busy)
        else $error("normal mode access length wrong");

    a_reset_access_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_start && !o_busy && i_mode == MODE_CM_RESET) |=> ##255 o_done ##1 !o_busy)
        else $error("memory reset access length wrong");

endmodule

// File: verilog/line_card_irq_and_mode_control.sv
// Purpose: Interrupt status, mask and operating mode registers of the switching core.
// Assumes: Host strobes arrive asynchronously; event inputs are on the system clock.
// Notes:   Demultiplexed bus addressing only; the reference clock is i_clk_sys.
`timescale 1ns/100ps

module line_card_irq_and_mode_control (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rstn,
    // Host parallel bus, demultiplexed.
    input  wire logic                           i_cs_n,
    input  wire logic                           i_rd_n,
    input  wire logic                           i_wr_n,
    input  wire logic [irq_mode_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [irq_mode_pkg::DATA_W-1:0] i_data,
    output logic      [irq_mode_pkg::DATA_W-1:0] o_data,
    output logic                                o_data_oe_n,
    output logic                                o_int_n,
    // Events from the neighbouring units.
    input  wire logic                           i_timer_expire,
    input  wire logic                           i_timer_irq_req,
    input  wire logic                           i_sigq_not_empty,
    input  wire logic                           i_mon_cmd_done,
    input  wire logic                           i_mon_found,
    input  wire logic                           i_pcm_sync_state,
    input  wire logic                           i_mismatch,
    input  wire logic                           i_compare_read,
    input  wire logic                           i_sync_chan_enabled,
    input  wire logic                           i_sync_window_open,
    input  wire logic                           i_sync_overrun,
    // Control memory access and mode outputs.
    input  wire logic                           i_mem_access_start,
    input  wire logic                           i_mem_full_tristate,
    output logic                                o_mem_access_busy,
    output logic                                o_mem_access_done,
    output logic                                o_mem_all_locations,
    output logic      [1:0]                     o_operating_mode_field,
    output logic                                o_interfaces_enabled,
    output logic                                o_monitor_handshake_select
);
    import irq_mode_pkg::*;

    localparam int PIN_W = 3 + ADDR_W + DATA_W;

    typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_t;

    logic [PIN_W-1:0]  pin_meta_reg;
    logic [PIN_W-1:0]  pin_sync_reg;
    logic              cs_n_s;
    logic              rd_n_s;
    logic              wr_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;

    bus_state_t        bus_state_reg;
    bus_state_t        bus_state_next;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] data_next;
    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] operating_mode_reg;
    logic              pcm_sync_prev_reg;
    logic              mismatch_armed_reg;
    logic              blank_reg;

    logic              read_start;
    logic              write_commit;
    logic              status_read;
    logic              mask_write;
    logic              mode_write;
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] irq_view;
    logic              irq_pending;
    logic              mismatch_set;

    // Host pins cross into the clock domain through two flops.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta_reg <= {3'h7, {(PIN_W-3){1'b0}}};
            pin_sync_reg <= {3'h7, {(PIN_W-3){1'b0}}};
        end else begin
            pin_meta_reg <= {i_cs_n, i_rd_n, i_wr_n, i_addr, i_data};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_sync_reg;

    // Reads act on strobe start; writes commit at strobe end so data has settled.
    assign read_start   = (bus_state_reg == BUS_IDLE) && !cs_n_s && !rd_n_s;
    assign write_commit = (bus_state_reg == BUS_WRITE) && wr_n_s;
    assign status_read  = read_start && (addr_s == INTERRUPT_STATUS_ADDR);
    assign mask_write   = write_commit && (addr_s == INTERRUPT_MASK_ADDR);
    assign mode_write   = write_commit && (addr_s == OPERATING_MODE_ADDR);

    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (!cs_n_s && !rd_n_s) begin
                    bus_state_next = BUS_READ;
                end else if (!cs_n_s && !wr_n_s) begin
                    bus_state_next = BUS_WRITE;
                end
            end
            BUS_READ: begin
                if (rd_n_s || cs_n_s) begin
                    bus_state_next = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (wr_n_s) begin
                    bus_state_next = BUS_IDLE;
                end
            end
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    assign data_next = !read_start ? data_reg
                     : status_read ? status_view
                     : (addr_s == OPERATING_MODE_ADDR) ? operating_mode_reg
                     : UNMAPPED_READ_VALUE;

    // Event sources for each flag.
    assign mismatch_set = i_mismatch && mismatch_armed_reg;
    assign set_vec[TIMER_EVENT_FLAG_BIT]           = i_timer_expire && i_timer_irq_req;
    assign set_vec[SIGNALING_QUEUE_FLAG_BIT]       = 1'b0;
    assign set_vec[MONITOR_COMMAND_DONE_FLAG_BIT]  = i_mon_cmd_done;
    assign set_vec[MONITOR_CHANNEL_FOUND_FLAG_BIT] = i_mon_found;
    assign set_vec[FRAMING_CHANGE_FLAG_BIT]        = i_pcm_sync_state ^ pcm_sync_prev_reg;
    assign set_vec[INPUT_MISMATCH_FLAG_BIT]        = mismatch_set;
    assign set_vec[SYNC_WINDOW_OPEN_FLAG_BIT]      = i_sync_window_open && i_sync_chan_enabled;
    assign set_vec[SYNC_OVERRUN_FLAG_BIT]          = i_sync_overrun;

    genvar g;
    generate
        for (g = 0; g < DATA_W; g++) begin : g_flag
            if (g == SIGNALING_QUEUE_FLAG_BIT) begin : g_queue
                // Queue flag mirrors the queue itself and shows even when masked.
                assign status_view[g] = i_sigq_not_empty;
            end else begin : g_cell
                event_flag_cell u_cell (
                    .i_clk_sys (i_clk_sys),
                    .i_rstn    (i_rstn),
                    .i_set     (set_vec[g]),
                    .i_clear   (status_read),
                    .i_mask    (mask_reg[g]),
                    .o_visible (status_view[g])
                );
            end
        end
    endgenerate

    assign irq_view    = status_view & ~mask_reg;
    assign irq_pending = |irq_view;
    assign o_int_n     = ~(irq_pending && !blank_reg);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_state_reg      <= BUS_IDLE;
            data_reg           <= INTERRUPT_STATUS_RESET;
            mask_reg           <= INTERRUPT_MASK_RESET;
            operating_mode_reg <= OPERATING_MODE_RESET;
            pcm_sync_prev_reg  <= 1'b0;
            mismatch_armed_reg <= 1'b1;
            blank_reg          <= 1'b0;
        end else begin
            bus_state_reg      <= bus_state_next;
            data_reg           <= data_next;
            mask_reg           <= mask_write ? data_s : mask_reg;
            operating_mode_reg <= mode_write ? data_s : operating_mode_reg;
            pcm_sync_prev_reg  <= i_pcm_sync_state;
            mismatch_armed_reg <= i_compare_read | (mismatch_armed_reg & ~i_mismatch);
            blank_reg          <= mask_write && irq_pending;
        end
    end

    assign o_data      = data_reg;
    assign o_data_oe_n = (bus_state_reg != BUS_READ);

    // Mode decoding.
    assign o_operating_mode_field =
        operating_mode_reg[OPERATING_MODE_FIELD_HI:OPERATING_MODE_FIELD_LO];
    assign o_interfaces_enabled =
        (o_operating_mode_field == MODE_NORMAL) || (o_operating_mode_field == MODE_TEST);
    assign o_mem_all_locations =
        (o_operating_mode_field == MODE_CM_RESET) || (o_operating_mode_field == MODE_TEST);
    assign o_monitor_handshake_select = operating_mode_reg[MONITOR_HANDSHAKE_SELECT_BIT];

    mem_access_timer u_access (
        .i_clk_sys       (i_clk_sys),
        .i_rstn          (i_rstn),
        .i_start         (i_mem_access_start),
        .i_full_tristate (i_mem_full_tristate),
        .i_mode          (o_operating_mode_field),
        .o_busy          (o_mem_access_busy),
        .o_done          (o_mem_access_done)
    );

    a_queue_flag_level: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        status_read |=> o_data[SIGNALING_QUEUE_FLAG_BIT] == $past(i_sigq_not_empty))
        else $error("queue flag does not follow the queue");

    a_read_clears_timer: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (status_read && status_view[TIMER_EVENT_FLAG_BIT]
         && !set_vec[TIMER_EVENT_FLAG_BIT]) |=> !status_view[TIMER_EVENT_FLAG_BIT])
        else $error("status read did not clear the timer flag");

    a_read_returns_status: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        status_read |=> o_data == $past(status_view) && !o_data_oe_n)
        else $error("status read returned wrong data");

    a_framing_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ($changed(i_pcm_sync_state) && !mask_reg[FRAMING_CHANGE_FLAG_BIT]
         && !mask_write) |=> status_view[FRAMING_CHANGE_FLAG_BIT])
        else $error("sync toggle did not set framing flag");

    a_mismatch_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ((mismatch_set && !i_compare_read) ##1 !i_compare_read [*2])
        |-> !mismatch_armed_reg)
        else $error("mismatch re-armed without compare read");

    a_masked_queue_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (mask_reg == 8'hFF) |-> o_int_n)
        else $error("fully masked state raised the interrupt");

    a_mask_write_blank: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (mask_write && irq_pending) |=> o_int_n)
        else $error("mask write did not blank the interrupt");

    a_int_follows_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (!blank_reg && |(status_view & ~mask_reg)) |-> !o_int_n)
        else $error("pending unmasked flag without interrupt");

    a_mode_write_field: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        mode_write |=> o_operating_mode_field == $past(data_s[7:6])
                       && o_monitor_handshake_select == $past(data_s[2]))
        else $error("mode write did not reach the mode fields");

endmodule

// File: dv/host_model.sv
// Purpose: Host processor model on the demultiplexed parallel bus.
// Assumes: Every task is entered 10 ns after a rising clock edge.
// Notes:   Released address and data are inverted so stale values never look valid.
`timescale 1ns/100ps
module host_model (
    input  wire logic       i_clk_sys,
    output logic            o_cs_n = 1'b1,
    output logic            o_rd_n = 1'b1,
    output logic            o_wr_n = 1'b1,
    output logic [7:0]      o_addr = 8'h00,
    output logic [7:0]      o_data = 8'h00,
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_oe_n
);
    // The strobes are synchronised inside the device, so four idle cycles keep spacing safe.
    task automatic gap();
        repeat (4) @(posedge i_clk_sys);
        #10;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        o_addr = a;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            @(posedge i_clk_sys);
            #10;
            ok = (i_data_oe_n === 1'b0);
        end
        d = i_data;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_addr = ~a;
        gap();
    endtask

    // Address and data stay put until well after the write strobe rises.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        o_addr = a;
        o_data = v;
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        gap();
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        gap();
        o_addr = ~a;
        o_data = ~v;
        gap();
    endtask
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the interrupt and operating mode block.
// Assumes: Inputs change 10 ns after the rising clock edge.
// Notes:   Mode register writes carry random low bits from an xorshift generator.
`timescale 1ns/100ps
module testbench;
    import irq_mode_pkg::*;
    logic        clk, rstn, cs_n, rd_n, wr_n, oe_n, int_n, irq_req, sigq, sync_st, cmp_rd;
    logic        chan_en, mstart, mtri, busy, done, all_loc, if_en, hs_sel, ok, watch, blank;
    logic [7:0]  addr, wdata, rdata, ev, d, v;
    logic [1:0]  mode_f;
    logic [1:0]  ml [5] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h1};
    logic [31:0] seed = 32'h24;
    int          bad_count = 0, compares = 0, n, nd;

    line_card_irq_and_mode_control dut (.i_clk_sys(clk), .i_rstn(rstn), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
        .o_data_oe_n(oe_n), .o_int_n(int_n), .i_timer_expire(ev[7]),
        .i_timer_irq_req(irq_req), .i_sigq_not_empty(sigq), .i_mon_cmd_done(ev[5]),
        .i_mon_found(ev[4]), .i_pcm_sync_state(sync_st), .i_mismatch(ev[2]),
        .i_compare_read(cmp_rd), .i_sync_chan_enabled(chan_en), .i_sync_window_open(ev[1]),
        .i_sync_overrun(ev[0]), .i_mem_access_start(mstart), .i_mem_full_tristate(mtri),
        .o_mem_access_busy(busy), .o_mem_access_done(done), .o_mem_all_locations(all_loc),
        .o_operating_mode_field(mode_f), .o_interfaces_enabled(if_en),
        .o_monitor_handshake_select(hs_sel));
    host_model host (.i_clk_sys(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_addr(addr), .o_data(wdata), .i_data(rdata), .i_data_oe_n(oe_n));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic int exp_len(input logic [1:0] m, input logic t);
        return m == 2'h0 ? 256 : m == 2'h2 ? 2 : m == 2'h1 ? 2057 : t ? 1035 : 10;
    endfunction
    task automatic test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, ok);
        if (!ok) begin
            bad_count++;
            $display("BAD t=%0t read got no answer", $time);
            test_done();
        end
        chk(d, exp);
    endtask
    task automatic pulse(input int b);
        ev[b] = 1'b1;
        step(1);
        ev = 8'h00;
        step(2);
    endtask
    // Any high level of the interrupt during a watched mask write counts as a blank.
    // Sampled on the falling edge so the one-cycle blank is seen after it has settled.
    always @(negedge clk) if (watch && int_n === 1'b1) blank <= 1'b1;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rstn, irq_req, sigq, sync_st, cmp_rd, chan_en, mstart, mtri, watch, blank} = '0;
        ev = 8'h00;
        step(20);
        rstn = 1'b1;
        step(2);
        rdc(8'h0E, 8'h00);
        rdc(8'h0F, 8'h00);
        seed = xs(seed);
        rdc({4'h1, seed[3:0]}, 8'h00);
        irq_req = 1'b1;
        chan_en = 1'b1;
        for (int b = 0; b < 8; b++) if (b != 3 && b != 6) begin
            pulse(b);
            chk({7'h0, int_n}, 8'h00);
            rdc(8'h0E, 8'h01 << b);
            rdc(8'h0E, 8'h00);
        end
        sync_st = 1'b1;
        step(3);
        rdc(8'h0E, 8'h08);
        pulse(2);
        rdc(8'h0E, 8'h00);
        cmp_rd = 1'b1;
        step(1);
        cmp_rd = 1'b0;
        pulse(2);
        rdc(8'h0E, 8'h04);
        chan_en = 1'b0;
        pulse(1);
        rdc(8'h0E, 8'h00);
        // An expiry of a timer started without interrupt generation must not set the flag.
        irq_req = 1'b0;
        pulse(7);
        rdc(8'h0E, 8'h00);
        irq_req = 1'b1;
        pulse(7);
        pulse(7);
        rdc(8'h0E, 8'h80);
        sigq = 1'b1;
        step(3);
        rdc(8'h0E, 8'h40);
        rdc(8'h0E, 8'h40);
        host.wr(8'h0E, 8'h40);
        chk({7'h0, int_n}, 8'h01);
        rdc(8'h0E, 8'h40);
        sigq = 1'b0;
        step(3);
        rdc(8'h0E, 8'h00);
        host.wr(8'h0E, 8'hFF);
        pulse(7);
        chk({7'h0, int_n}, 8'h01);
        rdc(8'h0E, 8'h00);
        host.wr(8'h0E, 8'h00);
        chk({7'h0, int_n}, 8'h00);
        rdc(8'h0E, 8'h80);
        pulse(5);
        blank = 1'b0;
        watch = 1'b1;
        host.wr(8'h0E, 8'h00);
        watch = 1'b0;
        chk({6'h0, blank, int_n}, 8'h02);
        rdc(8'h0E, 8'h20);
        // The first pass is the full memory reset that follows a hardware reset.
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            v = {ml[i], seed[5:0]};
            host.wr(8'h0F, v);
            rdc(8'h0F, v);
            chk({3'h0, mode_f, if_en, all_loc, hs_sel}, {3'h0, v[7:6], v[6], ~v[7], v[2]});
            mtri = (i == 3);
            mstart = 1'b1;
            step(1);
            mstart = 1'b0;
            n = 0;
            nd = 0;
            for (int k = 0; k < 2200; k++) begin
                // A second start inside a running access must be ignored.
                mstart = (k == 0);
                n += (busy === 1'b1);
                nd += (done === 1'b1);
                step(1);
            end
            chk({6'h0, n == exp_len(ml[i], mtri), nd == 1}, 8'h03);
        end
        test_done();
    end
endmodule
